/* File: sbtap_pkg.sv */
`default_nettype none
package sbtap_pkg;

    // instruction register width and codes
    localparam int unsigned IR_W          = 3;
    localparam logic [2:0]  IR_EXTEST     = 3'h0;
    localparam logic [2:0]  IR_IDCODE     = 3'h1;
    localparam logic [2:0]  IR_SAMPLE_Z   = 3'h2;
    localparam logic [2:0]  IR_RSVD_A     = 3'h3;
    localparam logic [2:0]  IR_SAMPLE     = 3'h4;
    localparam logic [2:0]  IR_RSVD_B     = 3'h5;
    localparam logic [2:0]  IR_RSVD_C     = 3'h6;
    localparam logic [2:0]  IR_BYPASS     = 3'h7;
    localparam logic [1:0]  IR_CAPTURE    = 2'h1;

    // boundary register length and output-bus tristate cell index
    localparam int unsigned BSR_LEN       = 89;
    localparam int unsigned OBT_BIT       = 88;

    // identification word layout
    localparam int unsigned ID_W          = 32;
    localparam int unsigned ID_REV_LSB    = 29;
    localparam int unsigned ID_DEV_LSB    = 12;
    localparam int unsigned ID_VEN_LSB    = 1;
    // arbitrary neutral identity values
    localparam logic [2:0]  ID_REV_RST    = 3'h0;
    localparam logic [16:0] ID_DEV_RST    = 17'h00001;
    localparam logic [10:0] ID_VEN_RST    = 11'h001;

    // pulled-up pins read high when nothing drives them
    localparam logic        PIN_PULL_VAL  = 1'h1;

    typedef enum logic [3:0] {
        ST_TLR      = 4'h0,
        ST_RTI      = 4'h1,
        ST_SEL_DR   = 4'h2,
        ST_CAP_DR   = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR   = 4'h8,
        ST_SEL_IR   = 4'h9,
        ST_CAP_IR   = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR   = 4'hF
    } sbtap_state_e;

    typedef enum logic [1:0] {
        PATH_BYP = 2'h0,
        PATH_ID  = 2'h1,
        PATH_BSR = 2'h2
    } sbtap_path_e;

    // serial pins as seen after synchronisation
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbtap_pins_s;

    // parallel face of the boundary register toward the output drivers
    typedef struct packed {
        logic [BSR_LEN-1:0] data;
        logic               drive_en;
        logic               out_hiz;
    } sbtap_ring_s;

endpackage
`default_nettype wire

/* File: sbtap_sync.sv */
`default_nettype none
module sbtap_sync #(
    parameter int unsigned W       = 1,
    parameter logic        RST_VAL = 1'h0
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sbtap_sync_s;

    sbtap_sync_s st_reg;
    sbtap_sync_s st_next;

    // first stage only feeds the second
    always_comb begin
        st_next.s1 = d;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg <= {2 * W{RST_VAL}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;
endmodule
`default_nettype wire

/* File: sbtap_top.sv */
// Overview of operation
// (RULE1) sample on test clock rise, change output on fall
// (RULE2) mode and data inputs read high when open; code only resets its pin synchroniser high
// (RULE3) shift in at top bit, out at bit zero
// (RULE4) five high mode edges reset the controller
// (RULE5) power-up reset leaves data out undriven
// (RULE6) three-bit instruction, identify loaded on reset
// (RULE7) capture-IR loads 01 into low bits
// (RULE8) instruction selects exactly one data path
// (RULE9) bypass bit cleared when bypass executes
// (RULE10) boundary instructions capture ring, then shift
// (RULE11) identify captures fixed 32-bit code, shifts out
// (RULE12) new instruction takes effect at Update-IR
// (RULE13) extest drives preloaded cells onto outputs
// (RULE14) sample-Z selects boundary path, outputs high-Z
// (RULE15) sample snapshots pins without disturbing memory
// (RULE16) preload latches pattern; capture and load overlap
// (RULE17) bypass is sole path during Shift-DR
// (RULE18) tristate cell latches at Update-DR, rules extest
// (RULE19) tristate cell high drives, low floats bus
// (RULE20) tristate cell preset high in reset
// (RULE21) controller never loads reserved instruction codes; code loads them at Update-IR and they select the bypass path
// (RULE22) test clock at most 20 MHz, stable capture
// (RULE23) codes: extest 000, id 001, Z 010, sample 100
// (RULE24) id: revision, device, vendor, bit zero one
// (RULE25) sixteen-state controller advances on mode value
// (RULE26) data out driven only in shift states
`default_nettype none
module sbtap_top
    import sbtap_pkg::*;
#(
    parameter logic [2:0]  ID_REV = ID_REV_RST,
    parameter logic [16:0] ID_DEV = ID_DEV_RST,
    parameter logic [10:0] ID_VEN = ID_VEN_RST
) (
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire logic               tck,
    input  wire logic               tms,
    input  wire logic               tdi,
    input  wire logic [BSR_LEN-1:0] ring_in,
    output var  logic               tdo,
    output var  logic               tdo_oe,
    output var  logic [BSR_LEN-1:0] ring_out,
    output var  logic               ring_drive_en,
    output var  logic               sram_out_hiz,
    output var  logic [IR_W-1:0]    instr_cur
);

    typedef struct packed {
        sbtap_state_e       st;
        logic [IR_W-1:0]    ir_sh;
        logic [IR_W-1:0]    ir;
        logic               byp;
        logic [ID_W-1:0]    idr;
        logic [BSR_LEN-1:0] bsr;
        logic [BSR_LEN-1:0] upd;
        logic               tck_d;
        logic               tdo;
        logic               tdo_oe;
    } sbtap_regs_s;

    localparam logic [ID_W-1:0] ID_WORD =
        {ID_REV, ID_DEV, ID_VEN, 1'h1};                     // [RULE24]

    sbtap_regs_s        st_reg;
    sbtap_regs_s        st_next;
    sbtap_pins_s        pins;
    logic [BSR_LEN-1:0] ring_s;
    logic               tck_rise;
    logic               tck_fall;
    sbtap_path_e        path;

    // controller transitions on the sampled mode bit
    function automatic sbtap_state_e next_state(sbtap_state_e s,
                                                logic m);
        sbtap_state_e n;
        n = s;
        unique case (s)
            ST_TLR:      n = m ? ST_TLR      : ST_RTI;
            ST_RTI:      n = m ? ST_SEL_DR   : ST_RTI;
            ST_SEL_DR:   n = m ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: n = m ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: n = m ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   n = m ? ST_SEL_DR   : ST_RTI;
            ST_SEL_IR:   n = m ? ST_TLR      : ST_CAP_IR;
            ST_CAP_IR:   n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: n = m ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: n = m ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   n = m ? ST_SEL_DR   : ST_RTI;
        endcase
        return n;
    endfunction

    // data path chosen by the current instruction
    function automatic sbtap_path_e dr_path(logic [IR_W-1:0] i);
        sbtap_path_e p;
        unique case (i)
            IR_IDCODE:                       p = PATH_ID;
            IR_EXTEST, IR_SAMPLE_Z, IR_SAMPLE: p = PATH_BSR;
            // reserved codes fall back to the one-bit path
            default:                         p = PATH_BYP;
        endcase
        return p;
    endfunction

    // pins reset to the pulled-up level; after reset an open pin is passed through, not read high
    sbtap_sync #(
        .W       (3),
        .RST_VAL (PIN_PULL_VAL)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       ({tck, tms, tdi}),
        .q       (pins)
    );                                                      // [RULE2]

    // ring crosses from the memory clock before it is captured
    sbtap_sync #(
        .W       (BSR_LEN),
        .RST_VAL (1'h0)
    ) u_ring_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (ring_in),
        .q       (ring_s)
    );

    // edges of the test clock found on the system clock
    assign tck_rise = pins.tck & ~st_reg.tck_d;
    assign tck_fall = ~pins.tck & st_reg.tck_d;
    assign path     = dr_path(st_reg.ir);                   // [RULE8]

    // all test state advances here
    always_comb begin
        st_next       = st_reg;
        st_next.tck_d = pins.tck;
        if (tck_rise) begin                                 // [RULE1]
            st_next.st = next_state(st_reg.st, pins.tms);  // [RULE25] [RULE4]
            unique case (st_reg.st)
                ST_CAP_IR: begin
                    st_next.ir_sh = {1'h0, IR_CAPTURE};     // [RULE7]
                end
                ST_SHIFT_IR: begin
                    st_next.ir_sh =
                        {pins.tdi, st_reg.ir_sh[IR_W-1:1]}; // [RULE3]
                end
                ST_UPD_IR: begin
                    st_next.ir = st_reg.ir_sh;              // [RULE12]
                end
                ST_CAP_DR: begin
                    unique case (path)
                        PATH_ID:  st_next.idr = ID_WORD;    // [RULE11]
                        PATH_BSR: st_next.bsr = ring_s;     // [RULE10] [RULE15]
                        PATH_BYP: st_next.byp = 1'h0;       // [RULE9]
                    endcase
                end
                ST_SHIFT_DR: begin
                    // capture leaves while preload data enters
                    unique case (path)
                        PATH_ID: begin
                            st_next.idr =
                                {pins.tdi, st_reg.idr[ID_W-1:1]};
                        end
                        PATH_BSR: begin
                            st_next.bsr = {pins.tdi,
                                st_reg.bsr[BSR_LEN-1:1]};   // [RULE16] [RULE3]
                        end
                        PATH_BYP: st_next.byp = pins.tdi;   // [RULE17]
                    endcase
                end
                ST_UPD_DR: begin
                    if (path == PATH_BSR) begin
                        st_next.upd = st_reg.bsr;           // [RULE16] [RULE18]
                    end
                end
                default: begin
                end
            endcase
        end
        // entering reset loads identify and presets the tristate cell high, on the
        // rise itself so nothing moves while the test clock is low
        if (tck_rise && st_next.st == ST_TLR) begin
            st_next.ir          = IR_IDCODE;                // [RULE6]
            st_next.upd[OBT_BIT] = 1'h1;                    // [RULE20]
        end
        // output only moves on the falling test clock edge
        if (tck_fall) begin                                 // [RULE1]
            st_next.tdo_oe = (st_reg.st == ST_SHIFT_IR) ||
                             (st_reg.st == ST_SHIFT_DR);    // [RULE26]
            if (st_reg.st == ST_SHIFT_IR) begin
                st_next.tdo = st_reg.ir_sh[0];              // [RULE3]
            end else begin
                unique case (path)
                    PATH_ID:  st_next.tdo = st_reg.idr[0];
                    PATH_BSR: st_next.tdo = st_reg.bsr[0];
                    PATH_BYP: st_next.tdo = st_reg.byp;
                endcase
            end
        end
    end

    // power-up reset puts the controller in its reset state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_reg       <= '0;
            st_reg.st    <= ST_TLR;                         // [RULE5]
            st_reg.ir    <= IR_IDCODE;                      // [RULE6]
            st_reg.ir_sh <= IR_IDCODE;
            st_reg.upd   <= BSR_LEN'(1) << OBT_BIT;         // [RULE20]
            st_reg.tck_d <= 1'h1;  // matches synced reset, no false rise
        end else begin
            st_reg <= st_next;
        end
    end

    // parallel outputs toward the memory output drivers
    always_comb begin
        ring_out      = st_reg.upd;
        ring_drive_en = 1'h0;
        sram_out_hiz  = 1'h0;                               // [RULE15]
        unique case (st_reg.ir)
            IR_EXTEST: begin
                ring_drive_en = st_reg.upd[OBT_BIT];        // [RULE13] [RULE19]
                sram_out_hiz  = ~st_reg.upd[OBT_BIT];       // [RULE18] [RULE19]
            end
            IR_SAMPLE_Z: begin
                sram_out_hiz  = 1'h1;                       // [RULE14]
            end
            default: begin
            end
        endcase
    end

    assign tdo       = st_reg.tdo;
    assign tdo_oe    = st_reg.tdo_oe;                       // [RULE5]
    assign instr_cur = st_reg.ir;                           // [RULE23]

endmodule
`default_nettype wire

/* File: sbtap_ctl.sv */
`default_nettype none
module sbtap_ctl
    import sbtap_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic tdo,
    input  wire logic tdo_oe,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle mode and data pins sit at their pull-up level, clock low
    initial begin
        tck = 1'h0;
        tms = PIN_PULL_VAL;
        tdi = PIN_PULL_VAL;
    end
    // one 225 ns period, far below the 20 MHz ceiling
    task automatic step(input logic m, input logic d, output logic o);
        @(posedge ref_clk);
        tck <= 1'h0;
        tms <= m;
        tdi <= d;
        repeat (5) @(posedge ref_clk);
        o = tdo_oe ? tdo : 1'hz;  // undriven pin gives no level
        tck <= 1'h1;
        repeat (3) @(posedge ref_clk);
    endtask
    // five high mode edges, then idle
    task automatic reset5;
        logic o;
        repeat (5) step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
    endtask
    // ring_in is held still across the whole pass
    task automatic scan(input logic ir, input int n,
                        input logic [BSR_LEN-1:0] din,
                        output logic [BSR_LEN-1:0] dout);
        logic o;
        dout = '0;
        step(1'h1, 1'h1, o);
        if (ir) step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
        step(1'h0, 1'h1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'h1, 1'h1, o);
        step(1'h0, 1'h1, o);
        // synced update needs a few system cycles to land
        repeat (4) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

/* File: sbtap_assertions.sv */
`default_nettype none
module sbtap_assertions
    import sbtap_pkg::*;
(
    input wire logic               ref_clk,
    input wire logic               rst_n,
    input wire logic               tck,
    input wire logic               tdo,
    input wire logic               tdo_oe,
    input wire logic [BSR_LEN-1:0] ring_out,
    input wire logic               ring_drive_en,
    input wire logic               sram_out_hiz,
    input wire logic [IR_W-1:0]    instr_cur
);
    timeunit 1ns;
    timeprecision 100ps;
    // reset values, checked without disable on purpose
    chk_reset_instr: assert property (@(posedge ref_clk)
        !rst_n |=> instr_cur == IR_IDCODE)
        else $error("instruction wrong after reset");
    chk_reset_oe: assert property (@(posedge ref_clk)
        !rst_n |=> !tdo_oe)
        else $error("data out driven after reset");
    chk_reset_cell: assert property (@(posedge ref_clk)
        !rst_n |=> ring_out[OBT_BIT])
        else $error("tristate cell not preset");
    // pin fall stays low five cycles, so a late change shows here
    chk_tdo_on_fall: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        ($changed(tdo) || $changed(tdo_oe)) |-> !tck && !$past(tck))
        else $error("data out changed outside low phase");
    chk_instr_on_rise: assert property (@(posedge ref_clk)
        disable iff (!rst_n) $changed(instr_cur) |-> tck || $past(tck))
        else $error("instruction changed outside rise");
    chk_update_on_rise: assert property (@(posedge ref_clk)
        disable iff (!rst_n) $changed(ring_out) |-> tck || $past(tck))
        else $error("update stage changed outside rise");
    chk_drive_rule: assert property (@(posedge ref_clk)
        disable iff (!rst_n)
        ring_drive_en == (instr_cur == IR_EXTEST && ring_out[OBT_BIT]))
        else $error("output drive enable wrong");
    chk_hiz_rule: assert property (@(posedge ref_clk)
        disable iff (!rst_n) sram_out_hiz == (instr_cur == IR_SAMPLE_Z ||
        (instr_cur == IR_EXTEST && !ring_out[OBT_BIT])))
        else $error("memory high-Z control wrong");
endmodule
bind sbtap_top sbtap_assertions sbtap_assertions_i (.ref_clk, .rst_n,
    .tck, .tdo, .tdo_oe, .ring_out, .ring_drive_en, .sram_out_hiz,
    .instr_cur);
`default_nettype wire

/* File: tb_sbtap_top.sv */
`default_nettype none
module tb_sbtap_top
    import sbtap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [88:0] RING_A = 89'h0AB_CDEF_0123_4567_89AB_CDEF;
    localparam logic [88:0] PRE_A  = 89'h0F0_F0F0_F0F0_F0F0_F0F0_F0F0;
    localparam logic [88:0] PRE_B  = 89'h100_0000_0000_0000_0000_00FF;
    logic               ref_clk;
    logic               rst_n;
    logic               tck, tms, tdi, tdo, tdo_oe, drv_en, out_hiz;
    logic [BSR_LEN-1:0] ring_in, ring_out, dout;
    logic [IR_W-1:0]    instr;
    int                 errors, n_compared, cycles;

    sbtap_top sbtap_top_i (.ref_clk, .rst_n, .tck, .tms, .tdi, .ring_in,
        .tdo, .tdo_oe, .ring_out, .ring_drive_en(drv_en),
        .sram_out_hiz(out_hiz), .instr_cur(instr));
    sbtap_ctl sbtap_ctl_i (.ref_clk, .tdo, .tdo_oe, .tck, .tms, .tdi);

    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [88:0] exp,
                       input logic [88:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // only implemented codes are ever loaded
    task automatic t_ir(input logic [2:0] code);
        sbtap_ctl_i.scan(1'h1, IR_W, 89'(code), dout);
        chk("ir capture", 89'(IR_CAPTURE), 89'(dout[1:0]));
        chk("instr", 89'(code), 89'(instr));
    endtask
    // 33 bits: the last one is the first data-in bit at the top
    task automatic t_idcode;
        sbtap_ctl_i.scan(1'h0, 33, '0, dout);
        chk("id", 89'({1'h0, ID_REV_RST, ID_DEV_RST, ID_VEN_RST, 1'h1}),
            dout);
        chk("oe", 89'h0, 89'(tdo_oe));
        $display("idcode test done");
    endtask
    task automatic t_bypass;
        t_ir(IR_BYPASS);
        sbtap_ctl_i.scan(1'h0, 2, 89'h1, dout);
        chk("bypass", 89'h2, dout);
        $display("bypass test done");
    endtask
    task automatic t_ring;
        ring_in <= RING_A;
        t_ir(IR_SAMPLE);
        sbtap_ctl_i.scan(1'h0, BSR_LEN, PRE_A, dout);
        chk("capture", RING_A, dout);
        chk("preload", PRE_A, ring_out);
        chk("hiz", 89'h0, 89'(out_hiz));
        t_ir(IR_EXTEST);
        chk("hiz", 89'h1, 89'(out_hiz));
        sbtap_ctl_i.scan(1'h0, BSR_LEN, PRE_B, dout);
        chk("capture", RING_A, dout);
        chk("ring out", PRE_B, ring_out);
        chk("drive", 89'h1, 89'(drv_en));
        t_ir(IR_SAMPLE_Z);
        chk("hiz", 89'h1, 89'(out_hiz));
        $display("ring test done");
    endtask
    // clear the tristate cell, then a mode-select reset
    task automatic t_reset;
        sbtap_ctl_i.scan(1'h0, BSR_LEN, PRE_A, dout);
        chk("cell", 89'h0, 89'(ring_out[OBT_BIT]));
        sbtap_ctl_i.reset5();
        chk("instr", 89'(IR_IDCODE), 89'(instr));
        chk("cell", 89'h1, 89'(ring_out[OBT_BIT]));
        $display("tap reset test done");
    endtask
    // run is about 3400 cycles, so this ceiling means a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        errors = 0;
        n_compared = 0;
        cycles = 0;
        rst_n = 1'h0;
        ring_in = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge ref_clk);
        chk("instr", 89'(IR_IDCODE), 89'(instr));
        chk("oe", 89'h0, 89'(tdo_oe));
        // scans start from run-test-idle, so leave reset first
        sbtap_ctl_i.reset5();
        t_idcode();
        t_bypass();
        t_ring();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
